// File: logic/nvm_prog_pkg.sv
package nvm_prog_pkg;

	////////////////////////////////////////////////////////////////////////
	// serial framing
	localparam int CMD_BITS = 8;
	localparam int PAY_BITS = 24;
	localparam int PAD_BITS = 6;
	localparam logic [4:0] CMD_LAST_BIT = 5'h07;
	localparam logic [4:0] PAY_FIRST_BIT = 5'h08;
	localparam logic [4:0] FRAME_LAST_BIT = 5'h1f;
	localparam int PAY_DATA_MSB = 16;
	localparam int PAY_DATA_LSB = 1;
	localparam int PAY_PC_MSB = 22;
	localparam int PAY_PC_LSB = 1;

	////////////////////////////////////////////////////////////////////////
	// command bytes
	localparam logic [7:0] CMD_LOAD_PC = 8'h80;
	localparam logic [7:0] CMD_BULK_ERASE = 8'h18;
	localparam logic [7:0] CMD_ROW_ERASE = 8'hf0;
	localparam logic [7:0] CMD_LOAD_DATA = 8'h00;
	localparam logic [7:0] CMD_LOAD_DATA_INC = 8'h02;
	localparam logic [7:0] CMD_READ = 8'hfc;
	localparam logic [7:0] CMD_READ_INC = 8'hfe;
	localparam logic [7:0] CMD_INC_ADDR = 8'hf8;
	localparam logic [7:0] CMD_PROG_INT = 8'he0;
	localparam logic [7:0] CMD_PROG_EXT = 8'hc0;

	////////////////////////////////////////////////////////////////////////
	// programming address map (byte addresses)
	localparam logic [21:0] PC_STEP = 22'h000002;
	localparam logic [21:0] UID_BASE = 22'h200000;
	localparam logic [21:0] UID_LAST = 22'h20000f;
	localparam logic [21:0] CFG_BASE = 22'h300000;
	localparam logic [21:0] CFG_LAST = 22'h300009;
	localparam logic [21:0] DIA_BASE = 22'h3f0000;
	localparam logic [21:0] DIA_LAST = 22'h3f003f;
	localparam logic [21:0] DCI_BASE = 22'h3fff00;
	localparam logic [21:0] DCI_LAST = 22'h3fff09;
	localparam logic [21:0] REV_ADDR = 22'h3ffffc;
	localparam logic [21:0] PART_ADDR = 22'h3ffffe;

	////////////////////////////////////////////////////////////////////////
	// array shapes and configuration bits
	localparam int ROW_WORDS = 32;
	localparam int UID_WORDS = 8;
	localparam int CFG_WORDS = 5;
	localparam logic [15:0] ERASED_WORD = 16'hffff;
	localparam logic [2:0] LVP_WORD = 3'h3;
	localparam int LVP_BIT = 13;
	localparam logic [2:0] RESET_PIN_FUNCTION_ENABLE_WORD = 3'h2;
	localparam int RESET_PIN_FUNCTION_ENABLE_BIT = 0;
	localparam logic [2:0] CP_WORD = 3'h4;
	localparam int CP_BIT = 0;

	////////////////////////////////////////////////////////////////////////
	// timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int T_PROG_INT_NS = 1000;
	localparam int T_ROW_ERASE_NS = 1000;
	localparam int PROG_INT_CYCLES = (T_PROG_INT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ROW_ERASE_CYCLES = (T_ROW_ERASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	////////////////////////////////////////////////////////////////////////
	// sequencer states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ERASE = 2'b01,
		ST_COMMIT = 2'b10,
		ST_HOLD = 2'b11
	} seq_state_type;

	// commands followed by a 24-clock payload
	function automatic logic cmd_has_payload(input logic [7:0] c);
		return (c == CMD_LOAD_PC) || (c == CMD_LOAD_DATA) || (c == CMD_LOAD_DATA_INC) ||
			(c == CMD_READ) || (c == CMD_READ_INC);
	endfunction

	// commands whose payload the device drives
	function automatic logic cmd_is_read(input logic [7:0] c);
		return (c == CMD_READ) || (c == CMD_READ_INC);
	endfunction

endpackage

// File: logic/serial_nvm_program_access.sv
`timescale 1ns/1ps
// Overview of operation
// - flash erases by row or in bulk
// - 32-word row latches; one row per write
// - erased reads one; writing only clears bits
// - write timed internally or externally; bulk scales
// - 32-clock entry key, msb first
// - low-voltage entry enable defaults to one
// - clearing that enable only under high voltage
// - high-voltage entry always possible
// - low-voltage mode: reset pin always reset
// - high voltage on reset pin enters programming
// - eight user id words, always readable
// - five configuration words at fixed base
// - factory info area read-only, ignores erase/write
// - config info area read-only, fixed values
// - read-only part id and revision words
// - revision word: six-bit major, six-bit minor
// - revision top nibble is family constant
// - beyond flash reads zero, no wrap
// - msb first; drive on rise, sample fall
// - low-voltage entry only on key match in the top 31 bits
// - address counter cleared on mode entry
module serial_nvm_program_access
	import nvm_prog_pkg::*;
#(
	parameter int FLASH_WORDS = 16384,
	parameter logic [3:0] FAMILY_CODE = 4'h5, // arbitrary value
	parameter logic [15:0] PART_ID = 16'h7c31, // arbitrary value
	parameter logic [5:0] MAJOR_REV = 6'h00,
	parameter logic [5:0] MINOR_REV = 6'h00,
	parameter logic [31:0] ENTRY_KEY = 32'h5a3c96e1, // arbitrary value
	parameter logic [15:0] DIA_WORD = 16'h0000,
	parameter logic [15:0] DCI_WORD = 16'h0000,
	parameter int BULK_ERASE_CYCLES = ROW_ERASE_CYCLES * (FLASH_WORDS / ROW_WORDS)
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic prog_serial_clock,
	input wire logic prog_serial_data_in,
	output logic prog_serial_data_out,
	output logic prog_serial_data_oe,
	input wire logic mode_select_reset_pin,
	input wire logic programming_high_voltage_level,
	output logic prog_mode,
	output logic lv_prog_mode,
	output logic core_reset,
	output logic reset_pin_general_input,
	output logic busy
);

	localparam int AW = $clog2(FLASH_WORDS);
	localparam int ROWS = FLASH_WORDS / ROW_WORDS;
	localparam logic [21:0] FLASH_END = 22'(2 * FLASH_WORDS);

	////////////////////////////////////////////////////////////////////////
	// link domain: entry key shifter, runs whenever the serial clock does
	logic [31:0] key_sh_r, key_sh_nxt;
	logic key_tgl_r, key_tgl_nxt;

	// slide one bit in per falling edge, msb first; last bit is don't care
	always_comb begin
		key_sh_nxt = {key_sh_r[30:0], prog_serial_data_in};
		key_tgl_nxt = key_tgl_r;
		if (key_sh_nxt[31:1] == ENTRY_KEY[31:1]) begin
			key_tgl_nxt = ~key_tgl_r;
		end
	end

	always_ff @(negedge prog_serial_clock or negedge arst_n) begin
		if (!arst_n) begin
			key_sh_r <= '0;
			key_tgl_r <= 1'b0;
		end else begin
			key_sh_r <= key_sh_nxt;
			key_tgl_r <= key_tgl_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// link domain: command and payload framer, held in reset outside mode
	logic prog_mode_r;
	logic link_rst_n;
	logic [4:0] bit_cnt_r, bit_cnt_nxt;
	logic [7:0] cmd_sh_r, cmd_sh_nxt;
	logic [7:0] cmd_r, cmd_nxt;
	logic [23:0] pay_sh_r, pay_sh_nxt;
	logic cmd_tgl_r, cmd_tgl_nxt;
	logic pay_tgl_r, pay_tgl_nxt;
	logic in_pay;

	// serial clock is idle whenever mode changes, so release needs no edge
	assign link_rst_n = arst_n & prog_mode_r;
	assign in_pay = (bit_cnt_r >= PAY_FIRST_BIT);

	// 8 command bits, then 24 payload bits when the command carries one
	always_comb begin
		bit_cnt_nxt = bit_cnt_r + 5'h01;
		cmd_sh_nxt = cmd_sh_r;
		cmd_nxt = cmd_r;
		pay_sh_nxt = pay_sh_r;
		cmd_tgl_nxt = cmd_tgl_r;
		pay_tgl_nxt = pay_tgl_r;
		if (!in_pay) begin
			cmd_sh_nxt = {cmd_sh_r[6:0], prog_serial_data_in};
			if (bit_cnt_r == CMD_LAST_BIT) begin
				cmd_nxt = cmd_sh_nxt;
				cmd_tgl_nxt = ~cmd_tgl_r;
				bit_cnt_nxt = cmd_has_payload(cmd_sh_nxt) ? PAY_FIRST_BIT : 5'h00;
			end
		end else begin
			pay_sh_nxt = {pay_sh_r[22:0], prog_serial_data_in};
			if (bit_cnt_r == FRAME_LAST_BIT) begin
				pay_tgl_nxt = ~pay_tgl_r;
				bit_cnt_nxt = 5'h00;
			end
		end
	end

	always_ff @(negedge prog_serial_clock or negedge link_rst_n) begin
		if (!link_rst_n) begin
			bit_cnt_r <= 5'h00;
			cmd_sh_r <= 8'h00;
			cmd_r <= 8'h00;
			pay_sh_r <= 24'h000000;
			cmd_tgl_r <= 1'b0;
			pay_tgl_r <= 1'b0;
		end else begin
			bit_cnt_r <= bit_cnt_nxt;
			cmd_sh_r <= cmd_sh_nxt;
			cmd_r <= cmd_nxt;
			pay_sh_r <= pay_sh_nxt;
			cmd_tgl_r <= cmd_tgl_nxt;
			pay_tgl_r <= pay_tgl_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// link domain: read payload driver on the rising edge
	logic [15:0] rd_word_r;
	logic [23:0] rd_frame;
	logic data_out_r, data_out_nxt;
	logic data_oe_r, data_oe_nxt;

	// start, pad, data, stop; rd_word_r is settled during the command delay
	assign rd_frame = {1'b0, {PAD_BITS{1'b0}}, rd_word_r, 1'b0};

	always_comb begin
		data_oe_nxt = in_pay && cmd_is_read(cmd_r);
		data_out_nxt = 1'b0;
		if (data_oe_nxt) begin
			data_out_nxt = rd_frame[FRAME_LAST_BIT - bit_cnt_r];
		end
	end

	always_ff @(posedge prog_serial_clock or negedge link_rst_n) begin
		if (!link_rst_n) begin
			data_out_r <= 1'b0;
			data_oe_r <= 1'b0;
		end else begin
			data_out_r <= data_out_nxt;
			data_oe_r <= data_oe_nxt;
		end
	end

	assign prog_serial_data_out = data_out_r;
	assign prog_serial_data_oe = data_oe_r;

	////////////////////////////////////////////////////////////////////////
	// clk domain: synchronisers for pins and link toggles
	logic hv_s1_r, hv_s2_r, pin_s1_r, pin_s2_r;
	logic [2:0] tgl_s1_r, tgl_s2_r, tgl_s3_r;
	logic key_ev, cmd_ev, pay_ev;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			hv_s1_r <= 1'b0;
			hv_s2_r <= 1'b0;
			pin_s1_r <= 1'b1;
			pin_s2_r <= 1'b1;
			tgl_s1_r <= 3'h0;
			tgl_s2_r <= 3'h0;
			tgl_s3_r <= 3'h0;
		end else begin
			hv_s1_r <= programming_high_voltage_level;
			hv_s2_r <= hv_s1_r;
			pin_s1_r <= mode_select_reset_pin;
			pin_s2_r <= pin_s1_r;
			tgl_s1_r <= {key_tgl_r, cmd_tgl_r, pay_tgl_r};
			tgl_s2_r <= tgl_s1_r;
			tgl_s3_r <= tgl_s2_r;
		end
	end

	assign {key_ev, cmd_ev, pay_ev} = tgl_s2_r ^ tgl_s3_r;

	////////////////////////////////////////////////////////////////////////
	// clk domain: memories and address decode
	logic [15:0] flash_mem [FLASH_WORDS];
	logic [15:0] row_latch_r [ROW_WORDS];
	logic [15:0] row_latch_nxt [ROW_WORDS];
	logic [15:0] uid_r [UID_WORDS];
	logic [15:0] uid_nxt [UID_WORDS];
	logic [15:0] cfg_r [CFG_WORDS];
	logic [15:0] cfg_nxt [CFG_WORDS];
	logic [ROWS-1:0] row_blank_r, row_blank_nxt;
	logic [21:0] pc_r, pc_nxt;
	logic in_flash, in_uid, in_cfg, lvp_bit, reset_pin_function_enable_bit, cp_on;
	logic [15:0] rd_map;

	assign in_flash = (pc_r < FLASH_END);
	assign in_uid = (pc_r >= UID_BASE) && (pc_r <= UID_LAST);
	assign in_cfg = (pc_r >= CFG_BASE) && (pc_r <= CFG_LAST);
	assign lvp_bit = cfg_r[LVP_WORD][LVP_BIT];
	assign reset_pin_function_enable_bit = cfg_r[RESET_PIN_FUNCTION_ENABLE_WORD][RESET_PIN_FUNCTION_ENABLE_BIT];
	assign cp_on = !cfg_r[CP_WORD][CP_BIT];

	// read view of the programming map at the current address
	always_comb begin
		rd_map = 16'h0000;
		if (in_flash) begin
			if (cp_on) begin
				rd_map = 16'h0000;
			end else if (row_blank_r[pc_r[AW:6]]) begin
				rd_map = ERASED_WORD;
			end else begin
				rd_map = flash_mem[pc_r[AW:1]];
			end
		end else if (in_uid) begin
			rd_map = uid_r[pc_r[3:1]];
		end else if (in_cfg) begin
			rd_map = cfg_r[pc_r[3:1]];
		end else if ((pc_r >= DIA_BASE) && (pc_r <= DIA_LAST)) begin
			rd_map = DIA_WORD;
		end else if ((pc_r >= DCI_BASE) && (pc_r <= DCI_LAST)) begin
			rd_map = DCI_WORD;
		end else if (pc_r[21:1] == REV_ADDR[21:1]) begin
			rd_map = {FAMILY_CODE, MAJOR_REV, MINOR_REV};
		end else if (pc_r[21:1] == PART_ADDR[21:1]) begin
			rd_map = PART_ID;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// clk domain: mode control and erase/write sequencer
	seq_state_type state_r, state_nxt;
	logic prog_mode_nxt, hv_mode_r, hv_mode_nxt, ext_r, ext_nxt;
	logic lv_mode_r, lv_mode_nxt;
	logic [31:0] tmr_r, tmr_nxt;
	logic [4:0] wcnt_r, wcnt_nxt;
	logic [15:0] rd_word_nxt;
	logic core_reset_r, core_reset_nxt, gen_in_r, gen_in_nxt, busy_r, busy_nxt;
	logic mem_we;
	logic [AW-1:0] mem_waddr;
	logic [15:0] mem_wdata, old_word, cfg_new;
	logic pin_func;

	assign old_word = flash_mem[{pc_r[AW:6], wcnt_r}];

	always_comb begin
		prog_mode_nxt = prog_mode_r;
		hv_mode_nxt = hv_mode_r;
		state_nxt = state_r;
		ext_nxt = ext_r;
		tmr_nxt = tmr_r;
		wcnt_nxt = wcnt_r;
		pc_nxt = pc_r;
		rd_word_nxt = rd_word_r;
		row_latch_nxt = row_latch_r;
		uid_nxt = uid_r;
		cfg_nxt = cfg_r;
		row_blank_nxt = row_blank_r;
		mem_we = 1'b0;
		mem_waddr = {pc_r[AW:6], wcnt_r};
		mem_wdata = row_latch_r[wcnt_r];
		cfg_new = cfg_r[pc_r[3:1]] & row_latch_r[pc_r[5:1]];
		if (!hv_mode_r && (pc_r[3:1] == LVP_WORD)) begin
			cfg_new[LVP_BIT] = cfg_r[LVP_WORD][LVP_BIT];
		end
		if (!prog_mode_r) begin
			// entry: high voltage always wins; low voltage needs key and enable
			if (hv_s2_r) begin
				prog_mode_nxt = 1'b1;
				hv_mode_nxt = 1'b1;
			end else if (key_ev && !pin_s2_r && lvp_bit) begin
				prog_mode_nxt = 1'b1;
				hv_mode_nxt = 1'b0;
			end
			if (prog_mode_nxt) begin
				pc_nxt = 22'h000000;
				state_nxt = ST_IDLE;
				row_latch_nxt = '{default: ERASED_WORD};
			end
		end else if (hv_mode_r ? !hv_s2_r : pin_s2_r) begin
			prog_mode_nxt = 1'b0;
			state_nxt = ST_IDLE;
		end else begin
			unique case (state_r)
				ST_IDLE: begin
					if (cmd_ev) begin
						unique case (cmd_r)
							CMD_INC_ADDR: pc_nxt = pc_r + PC_STEP;
							CMD_READ, CMD_READ_INC: rd_word_nxt = rd_map;
							CMD_ROW_ERASE: begin
								if (in_flash) begin
									row_blank_nxt[pc_r[AW:6]] = 1'b1;
									tmr_nxt = 32'(ROW_ERASE_CYCLES - 1);
									state_nxt = ST_ERASE;
								end
							end
							CMD_BULK_ERASE: begin
								if (in_flash || in_uid || in_cfg) begin
									row_blank_nxt = '1;
									uid_nxt = '{default: ERASED_WORD};
									if (in_cfg) begin
										cfg_nxt = '{default: ERASED_WORD};
									end
									tmr_nxt = 32'(BULK_ERASE_CYCLES - 1);
									state_nxt = ST_ERASE;
								end
							end
							CMD_PROG_INT, CMD_PROG_EXT: begin
								ext_nxt = (cmd_r == CMD_PROG_EXT);
								tmr_nxt = 32'(PROG_INT_CYCLES - 1);
								wcnt_nxt = 5'h00;
								if (in_flash) begin
									state_nxt = ST_COMMIT;
								end else if (in_uid) begin
									uid_nxt[pc_r[3:1]] = uid_r[pc_r[3:1]] & row_latch_r[pc_r[5:1]];
									state_nxt = ST_HOLD;
								end else if (in_cfg) begin
									cfg_nxt[pc_r[3:1]] = cfg_new;
									state_nxt = ST_HOLD;
								end
								// other ranges are read-only or reserved
							end
							default: begin
							end
						endcase
					end else if (pay_ev) begin
						if (cmd_r == CMD_LOAD_PC) begin
							pc_nxt = pay_sh_r[PAY_PC_MSB:PAY_PC_LSB];
						end else if ((cmd_r == CMD_LOAD_DATA) || (cmd_r == CMD_LOAD_DATA_INC)) begin
							row_latch_nxt[pc_r[5:1]] = pay_sh_r[PAY_DATA_MSB:PAY_DATA_LSB];
							if (cmd_r == CMD_LOAD_DATA_INC) begin
								pc_nxt = pc_r + PC_STEP;
							end
						end else if (cmd_r == CMD_READ_INC) begin
							pc_nxt = pc_r + PC_STEP;
						end
					end
				end
				ST_ERASE: begin
					tmr_nxt = tmr_r - 32'h00000001;
					if (tmr_r == 32'h00000000) begin
						state_nxt = ST_IDLE;
					end
				end
				ST_COMMIT: begin
					// one word per cycle; a blank row takes the latch as is
					mem_we = 1'b1;
					mem_wdata = row_blank_r[pc_r[AW:6]] ? row_latch_r[wcnt_r] :
						(old_word & row_latch_r[wcnt_r]);
					wcnt_nxt = wcnt_r + 5'h01;
					if (wcnt_r == 5'(ROW_WORDS - 1)) begin
						row_blank_nxt[pc_r[AW:6]] = 1'b0;
						row_latch_nxt = '{default: ERASED_WORD};
						state_nxt = ST_HOLD;
					end
				end
				ST_HOLD: begin
					// external timing ends on the next command byte, which is consumed
					if (ext_r) begin
						if (cmd_ev) begin
							state_nxt = ST_IDLE;
						end
					end else begin
						tmr_nxt = tmr_r - 32'h00000001;
						if (tmr_r == 32'h00000000) begin
							state_nxt = ST_IDLE;
						end
					end
				end
			endcase
		end
		// pin is a reset whenever low-voltage entry or the reset pin function enable bit is set, or in low-voltage mode
		pin_func = lvp_bit || reset_pin_function_enable_bit || (prog_mode_nxt && !hv_mode_nxt);
		core_reset_nxt = prog_mode_nxt || (pin_func && !pin_s2_r);
		gen_in_nxt = !pin_func;
		busy_nxt = prog_mode_nxt && (state_nxt != ST_IDLE);
		lv_mode_nxt = prog_mode_nxt && !hv_mode_nxt;
	end

	// flash array has no reset; erased rows are tracked by row_blank_r
	always_ff @(posedge clk) begin
		if (mem_we) begin
			flash_mem[mem_waddr] <= mem_wdata;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			prog_mode_r <= 1'b0;
			hv_mode_r <= 1'b0;
			state_r <= ST_IDLE;
			ext_r <= 1'b0;
			tmr_r <= 32'h00000000;
			wcnt_r <= 5'h00;
			pc_r <= 22'h000000;
			rd_word_r <= 16'h0000;
			row_latch_r <= '{default: ERASED_WORD};
			uid_r <= '{default: ERASED_WORD};
			cfg_r <= '{default: ERASED_WORD};
			row_blank_r <= '1;
			core_reset_r <= 1'b0;
			gen_in_r <= 1'b0;
			busy_r <= 1'b0;
			lv_mode_r <= 1'b0;
		end else begin
			prog_mode_r <= prog_mode_nxt;
			hv_mode_r <= hv_mode_nxt;
			state_r <= state_nxt;
			ext_r <= ext_nxt;
			tmr_r <= tmr_nxt;
			wcnt_r <= wcnt_nxt;
			pc_r <= pc_nxt;
			rd_word_r <= rd_word_nxt;
			row_latch_r <= row_latch_nxt;
			uid_r <= uid_nxt;
			cfg_r <= cfg_nxt;
			row_blank_r <= row_blank_nxt;
			core_reset_r <= core_reset_nxt;
			gen_in_r <= gen_in_nxt;
			busy_r <= busy_nxt;
			lv_mode_r <= lv_mode_nxt;
		end
	end

	assign prog_mode = prog_mode_r;
	assign lv_prog_mode = lv_mode_r;
	assign core_reset = core_reset_r;
	assign reset_pin_general_input = gen_in_r;
	assign busy = busy_r;

endmodule

// File: test/nvm_host.sv
`timescale 1ns/1ps
// behavioural programmer driving the serial link
module nvm_host (
	output logic sclk,
	output logic hd,
	input wire logic dline
);
	// clock stands low outside frames
	initial begin
		sclk = 1'b0;
		hd = 1'b0;
	end
	////////////////////////////////////////////////
	// shift n bits msb first, data moves after rise
	task automatic bits(input logic [31:0] v, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			sclk = 1'b1;
			#1 hd = v[i];
			#61.5 sclk = 1'b0;
			#62.5;
		end
	endtask
	// command byte then the settle gap
	task automatic cmd(input logic [7:0] c);
		bits({24'h000000, c}, 8);
		#500;
	endtask
	// host payload, framing bits low
	task automatic put(input logic [23:0] p);
		bits({8'h00, p}, 24);
		#500;
	endtask
	// device payload; line released, own drive toggles
	task automatic get(output logic [15:0] w);
		logic [23:0] r;
		r = '0;
		for (int i = 0; i < 24; i++) begin
			sclk = 1'b1;
			#1 hd = ~hd;
			#61 r = {r[22:0], dline};
			#0.5 sclk = 1'b0;
			#62.5;
		end
		w = r[16:1];
		#500;
	endtask
endmodule

// File: test/nvm_prog_sva.sv
`timescale 1ns/1ps
// mode and pin relations seen at the top ports
module nvm_prog_sva (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic prog_serial_clock,
	input wire logic prog_serial_data_in,
	input wire logic prog_serial_data_out,
	input wire logic prog_serial_data_oe,
	input wire logic mode_select_reset_pin,
	input wire logic programming_high_voltage_level,
	input wire logic prog_mode,
	input wire logic lv_prog_mode,
	input wire logic core_reset,
	input wire logic reset_pin_general_input,
	input wire logic busy
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	////////////////////////////////////////////////
	// mode flags
	chk_lv_in_mode: assert property (lv_prog_mode |-> prog_mode)
		else $error("low-voltage flag without program mode");
	chk_mode_core_rst: assert property (prog_mode |-> core_reset)
		else $error("program mode without core reset");
	chk_lv_pin_func: assert property (lv_prog_mode |-> core_reset && !reset_pin_general_input)
		else $error("pin not a reset in low-voltage mode");
	chk_lv_low_pin: assert property ($rose(lv_prog_mode) |-> !mode_select_reset_pin)
		else $error("low-voltage entry with pin high");
	// entry and exit timing
	chk_hv_entry: assert property ($rose(programming_high_voltage_level) |-> ##[1:6] prog_mode)
		else $error("no entry on high voltage");
	chk_hv_source: assert property ($rose(prog_mode) && !lv_prog_mode
		|-> $past(programming_high_voltage_level, 2))
		else $error("entry without key or high voltage");
	chk_lv_exit: assert property ($rose(mode_select_reset_pin) && lv_prog_mode
		|-> ##[1:6] !prog_mode)
		else $error("low-voltage mode kept with pin high");
	chk_hv_exit: assert property ($fell(programming_high_voltage_level) && prog_mode
		&& !lv_prog_mode |-> ##[1:6] !prog_mode)
		else $error("high-voltage mode kept after removal");
	chk_hv_held: assert property (prog_mode && !lv_prog_mode
		|-> programming_high_voltage_level || $past(programming_high_voltage_level, 3))
		else $error("high-voltage mode without high voltage");
	// link driver and sequencer only in mode
	chk_oe_idle: assert property (!prog_mode |-> !prog_serial_data_oe)
		else $error("data driven outside program mode");
	chk_busy_mode: assert property ($rose(busy) |-> prog_mode)
		else $error("sequencer started outside program mode");
endmodule
bind serial_nvm_program_access nvm_prog_sva u_nvm_prog_sva (.clk(clk), .arst_n(arst_n),
	.prog_serial_clock(prog_serial_clock), .prog_serial_data_in(prog_serial_data_in),
	.prog_serial_data_out(prog_serial_data_out), .prog_serial_data_oe(prog_serial_data_oe),
	.mode_select_reset_pin(mode_select_reset_pin),
	.programming_high_voltage_level(programming_high_voltage_level),
	.prog_mode(prog_mode), .lv_prog_mode(lv_prog_mode), .core_reset(core_reset),
	.reset_pin_general_input(reset_pin_general_input), .busy(busy));

// File: test/testbench.sv
`timescale 1ns/1ps
module testbench;
	import nvm_prog_pkg::*;
	localparam logic [15:0] PID = 16'h7c31; // arbitrary value
	localparam logic [3:0] FAM = 4'h5; // arbitrary value
	localparam logic [31:0] KEY = 32'h5a3c96e1; // arbitrary value
	localparam logic [5:0] MJ = 6'h03;
	localparam logic [5:0] MN = 6'h15;
	localparam logic [21:0] RA [6] = '{PART_ADDR, REV_ADDR, DIA_BASE, DCI_BASE, 22'h000800,
		22'h200010};
	localparam logic [15:0] RE [6] = '{PID, {FAM, MJ, MN}, 16'h1234, 16'h4321, 16'h0000,
		16'h0000};
	localparam logic [21:0] CW3 = CFG_BASE + 22'h000006;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic pin = 1'b1;
	logic hv = 1'b0;
	wire logic sclk, hd, dout, oe, pm, lvm, crst, gpi, busy;
	wire logic dline = oe ? dout : hd;
	int error_cnt = 0;
	int n_tests = 0;
	logic [15:0] w;
	// system clock
	always #25 clk = ~clk;
	serial_nvm_program_access #(.FLASH_WORDS(1024), .FAMILY_CODE(FAM), .PART_ID(PID),
		.MAJOR_REV(MJ), .MINOR_REV(MN), .ENTRY_KEY(KEY), .DIA_WORD(16'h1234),
		.DCI_WORD(16'h4321), .BULK_ERASE_CYCLES(40)) u_serial_nvm_program_access (
		.clk(clk), .arst_n(arst_n), .prog_serial_clock(sclk), .prog_serial_data_in(dline),
		.prog_serial_data_out(dout), .prog_serial_data_oe(oe), .mode_select_reset_pin(pin),
		.programming_high_voltage_level(hv), .prog_mode(pm), .lv_prog_mode(lvm),
		.core_reset(crst), .reset_pin_general_input(gpi), .busy(busy));
	nvm_host u_nvm_host (.sclk(sclk), .hd(hd), .dline(dline));
	////////////////////////////////////////////////
	// compare and verdict
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic complete_run();
		$display("comparisons=%0d mismatches=%0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// link transactions
	task automatic ld_pc(input logic [21:0] a);
		u_nvm_host.cmd(CMD_LOAD_PC);
		u_nvm_host.put({1'b0, a, 1'b0});
	endtask
	task automatic rd(input logic [21:0] a, output logic [15:0] v);
		ld_pc(a);
		u_nvm_host.cmd(CMD_READ);
		u_nvm_host.get(v);
	endtask
	task automatic idle();
		for (int i = 0; i < 2000 && busy !== 1'b0; i++) @(posedge clk);
		check({15'h0000, busy}, 16'h0000);
	endtask
	task automatic er(input logic [21:0] a, input logic [7:0] c);
		ld_pc(a);
		u_nvm_host.cmd(c);
		idle();
	endtask
	task automatic prog(input logic [21:0] a, input logic [15:0] b, input logic ext);
		ld_pc(a);
		for (int i = 0; i < ROW_WORDS; i++) begin
			u_nvm_host.cmd(CMD_LOAD_DATA_INC);
			u_nvm_host.put({7'h00, b + 16'(i), 1'b0});
		end
		ld_pc(a);
		u_nvm_host.cmd(ext ? CMD_PROG_EXT : CMD_PROG_INT);
		if (ext) begin
			repeat (60) @(posedge clk);
			check({15'h0000, busy}, 16'h0001);
			u_nvm_host.cmd(CMD_INC_ADDR);
		end
		idle();
	endtask
	// read-only and empty places
	task automatic sweep();
		for (int i = 0; i < 6; i++) begin
			rd(RA[i], w);
			check(w, RE[i]);
		end
	endtask
	task automatic pins(input logic p, input logic h);
		@(posedge clk);
		pin <= p;
		hv <= h;
		repeat (8) @(posedge clk);
	endtask
	// watchdog
	initial begin
		#(50 * 90000);
		error_cnt++;
		complete_run();
	end
	////////////////////////////////////////////////
	// test sequence
	initial begin
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		repeat (3) @(posedge clk);
		check({15'h0000, pm}, 16'h0000);
		pins(1'b1, 1'b1);
		check({14'h0000, pm, lvm}, 16'h0002);
		sweep();
		rd(UID_BASE, w);
		check(w, ERASED_WORD);
		$display("test hv_map done");
		prog(22'h000000, 16'h1230, 1'b0);
		rd(22'h00003e, w);
		check(w, 16'h124f);
		er(22'h000000, CMD_ROW_ERASE);
		prog(22'h000000, 16'hff00, 1'b1);
		rd(22'h000000, w);
		check(w, 16'hff00);
		prog(22'h000040, 16'h0a00, 1'b0);
		er(22'h000000, CMD_ROW_ERASE);
		rd(22'h000000, w);
		check(w, ERASED_WORD);
		rd(22'h000040, w);
		check(w, 16'h0a00);
		er(22'h000000, CMD_BULK_ERASE);
		rd(22'h000040, w);
		check(w, ERASED_WORD);
		prog(DIA_BASE, 16'h0000, 1'b0);
		prog(REV_ADDR, 16'h0000, 1'b0);
		er(DCI_BASE, CMD_ROW_ERASE);
		prog(22'h000800, 16'h0000, 1'b0);
		sweep();
		prog(22'h000000, 16'h5550, 1'b0);
		prog(UID_BASE, 16'h00a5, 1'b0);
		rd(UID_BASE, w);
		check(w, 16'h00a5);
		prog(UID_BASE, 16'h0f0f, 1'b0);
		rd(UID_BASE, w);
		check(w, 16'h0005);
		$display("test erase_write done");
		pins(1'b0, 1'b0);
		check({15'h0000, pm}, 16'h0000);
		u_nvm_host.bits(KEY ^ 32'h80000000, 32);
		repeat (10) @(posedge clk);
		check({15'h0000, pm}, 16'h0000);
		u_nvm_host.bits(KEY ^ 32'h00000001, 32);
		repeat (10) @(posedge clk);
		check({12'h000, pm, lvm, crst, gpi}, 16'h000e);
		u_nvm_host.cmd(CMD_READ_INC);
		u_nvm_host.get(w);
		check(w, 16'h5550);
		u_nvm_host.cmd(CMD_INC_ADDR);
		u_nvm_host.cmd(CMD_READ);
		u_nvm_host.get(w);
		check(w, 16'h5552);
		prog(CW3, 16'hdfff, 1'b0);
		rd(CW3, w);
		check(w, ERASED_WORD);
		pins(1'b1, 1'b0);
		check({15'h0000, pm}, 16'h0000);
		$display("test lv_entry done");
		pins(1'b1, 1'b1);
		prog(CW3, 16'hdfff, 1'b0);
		rd(CW3, w);
		check(w, 16'hdfff);
		rd(CFG_BASE + 22'h000008, w);
		check(w, ERASED_WORD);
		rd(CFG_BASE + 22'h00000a, w);
		check(w, 16'h0000);
		pins(1'b0, 1'b0);
		u_nvm_host.bits(KEY, 32);
		repeat (10) @(posedge clk);
		check({15'h0000, pm}, 16'h0000);
		pins(1'b1, 1'b1);
		check({14'h0000, pm, lvm}, 16'h0002);
		$display("test lv_lockout done");
		complete_run();
	end
endmodule
